/* iosam_pkg.sv */
// Purpose: Shared constants and carriers for the I/O signal assignment map.
// Assumes: Function codes are 6 bits; 64 codes cover every assignable signal.
// Notes:   Codes are grouped so that range checks are a simple prefix test.
package iosam_pkg;

  localparam int unsigned CODE_W     = 6;
  localparam int unsigned NCODE      = 64;
  localparam int unsigned N_DIN      = 8;
  localparam int unsigned N_DOUT     = 8;
  localparam int unsigned N_RIN      = 16;
  localparam int unsigned N_ROUT     = 16;
  localparam int unsigned N_PROG     = 16;
  localparam int unsigned N_MAP      = N_DIN + N_DOUT + N_RIN + N_ROUT;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // Map slot bases inside the configuration array
  localparam int unsigned SLOT_DIN   = 0;
  localparam int unsigned SLOT_DOUT  = SLOT_DIN + N_DIN;
  localparam int unsigned SLOT_RIN   = SLOT_DOUT + N_DOUT;
  localparam int unsigned SLOT_ROUT  = SLOT_RIN + N_RIN;

  // Register byte addresses; map slot k sits at OFS_MAP + 4*k
  localparam logic [ADDR_W-1:0] OFS_MAP      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FUNC_LO  = 8'hc0;
  localparam logic [ADDR_W-1:0] OFS_FUNC_HI  = 8'hc4;
  localparam logic [ADDR_W-1:0] OFS_DIRECT   = 8'hc8;
  localparam logic [ADDR_W-1:0] OFS_REMOTE   = 8'hcc;
  localparam logic [ADDR_W-1:0] OFS_PROG_OUT = 8'hd0;

  // Input function codes
  localparam logic [CODE_W-1:0] IN_UNUSED          = 6'h00;
  localparam logic [CODE_W-1:0] IN_STOP            = 6'h01;
  localparam logic [CODE_W-1:0] IN_AXES_UNPOWER    = 6'h02;
  localparam logic [CODE_W-1:0] IN_OVERTRAVEL_CLR  = 6'h03;
  localparam logic [CODE_W-1:0] IN_ALARM_CLEAR     = 6'h04;
  localparam logic [CODE_W-1:0] IN_PAUSE           = 6'h05;
  localparam logic [CODE_W-1:0] IN_EMERGENCY_HALT  = 6'h06;
  localparam logic [CODE_W-1:0] IN_TOOL_UNLOCK     = 6'h07;
  localparam logic [CODE_W-1:0] IN_PROG_DIRECT     = 6'h10;
  localparam logic [CODE_W-1:0] IN_PROG_REMOTE     = 6'h20;

  // Output source codes
  localparam logic [CODE_W-1:0] OUT_UNUSED         = 6'h00;
  localparam logic [CODE_W-1:0] OUT_READY          = 6'h01;
  localparam logic [CODE_W-1:0] OUT_MOTION         = 6'h02;
  localparam logic [CODE_W-1:0] OUT_OVERTRAVEL_MON = 6'h03;
  localparam logic [CODE_W-1:0] OUT_ALARM_LOW      = 6'h04;
  localparam logic [CODE_W-1:0] OUT_PAUSE_BUSY     = 6'h05;
  localparam logic [CODE_W-1:0] OUT_PROG_RUNNING   = 6'h06;
  localparam logic [CODE_W-1:0] OUT_PROG_DIRECT    = 6'h10;
  localparam logic [CODE_W-1:0] OUT_PROG_REMOTE    = 6'h20;

  // Prefix masks for the program groups (16 codes each)
  localparam logic [CODE_W-1:0] GROUP_MASK         = 6'h30;

  // Default assignment after reset, per map slot
  function automatic logic [CODE_W-1:0] iosam_default(input int unsigned k);
    logic [CODE_W-1:0] c;
    c = IN_UNUSED;
    case (k)
      0:  c = IN_STOP;
      1:  c = IN_AXES_UNPOWER;
      2:  c = IN_OVERTRAVEL_CLR;
      3:  c = IN_ALARM_CLEAR;
      4:  c = IN_PAUSE;
      5:  c = IN_UNUSED;
      6:  c = IN_PROG_DIRECT;
      7:  c = IN_PROG_DIRECT + 6'h01;
      8:  c = OUT_READY;
      9:  c = OUT_MOTION;
      10: c = OUT_OVERTRAVEL_MON;
      11: c = OUT_ALARM_LOW;
      12: c = OUT_PAUSE_BUSY;
      13: c = OUT_PROG_RUNNING;
      14: c = OUT_PROG_DIRECT;
      15: c = OUT_PROG_DIRECT + 6'h01;
      default: begin
        if (k >= SLOT_ROUT) begin
          c = OUT_PROG_REMOTE | CODE_W'(k - SLOT_ROUT);
        end else begin
          c = IN_PROG_REMOTE | CODE_W'(k - SLOT_RIN);
        end
      end
    endcase
    return c;
  endfunction

  // Controller state shown on outputs
  typedef struct packed {
    logic ready;
    logic motion_active;
    logic driver_overtravel_monitor;
    logic alarm;
    logic pause_busy;
    logic program_running;
  } iosam_status_t;

  // Program signal-output command
  typedef struct packed {
    logic                valid;
    logic                to_remote;
    logic [3:0]          index;
    logic                value;
    logic                clear_direct;
    logic                clear_remote;
  } iosam_cmd_t;

  // Resolved input functions toward the controller core
  typedef struct packed {
    logic              stop;
    logic              robot_axes_unpower;
    logic              driver_overtravel_clear;
    logic              alarm_clear;
    logic              pause;
    logic              halt_request;
    logic              operator_tool_unlock;
    logic [N_PROG-1:0] program_direct_input;
    logic [N_PROG-1:0] program_remote_input;
  } iosam_func_t;

endpackage

/* iosam_resolve.sv */
// Purpose: OR-combine a group of terminals onto the input function codes.
// Assumes: Codes and levels are stable within the cycle; purely combinational.
// Notes:   A code outside the allowed mask is treated as assigned to nothing.
`timescale 1ns/1ps
module iosam_resolve #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0]                          lvl,
  input  wire logic [N-1:0][iosam_pkg::CODE_W-1:0]   codes,
  input  wire logic [iosam_pkg::NCODE-1:0]           allow,
  output      logic [iosam_pkg::NCODE-1:0]           hit,
  output      logic [iosam_pkg::NCODE-1:0]           assigned
);
  import iosam_pkg::*;

  // One match row per function code
  for (genvar f = 0; f < NCODE; f++) begin : g_func
    logic [N-1:0] match;
    for (genvar t = 0; t < N; t++) begin : g_term
      assign match[t] = (codes[t] == CODE_W'(f)) & allow[f];
    end
    assign hit[f]      = |(match & lvl);
    assign assigned[f] = |match;
  end

endmodule

/* iosam_top.sv */
// Purpose: Signal assignment map between I/O terminals, remote bits and functions.
// Assumes: All inputs synchronous to sys_clk; remote bits arrive from the network stack.
// Notes:   Map registers are one aligned word each; unmapped reads return zero.
//
// How it works
// - Eight direct inputs and outputs, each with a function-select parameter register.
// - Direct outputs reset to ready, motion, monitor, alarm-low, busy, running, prog outs.
// - A function on several terminals is active when any terminal is active.
// - Emergency halt and tool unlock read ON when assigned nowhere.
// - Assigned on both direct and remote sides, they are ON only if both are.
// - Sixteen host-written remote inputs, each mapped; default program remote input n.
// - Sixteen remote outputs, each mapped; default program remote output n.
// - Program remote outputs set only by program command, reachable only remotely.
// - Emergency halt is normally closed: OFF halts everything, ON permits.
`timescale 1ns/1ps
module iosam_top (
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  input  wire logic [iosam_pkg::ADDR_W-1:0]   addr,
  input  wire logic [iosam_pkg::DATA_W-1:0]   wdata,
  input  wire logic                           wr_stb,
  input  wire logic                           rd_stb,
  output      logic [iosam_pkg::DATA_W-1:0]   rdata,
  input  wire logic [iosam_pkg::N_DIN-1:0]    direct_in,
  output      logic [iosam_pkg::N_DOUT-1:0]   direct_out,
  input  wire logic [iosam_pkg::N_RIN-1:0]    remote_in,
  output      logic [iosam_pkg::N_ROUT-1:0]   remote_out,
  input  wire iosam_pkg::iosam_status_t       status,
  input  wire iosam_pkg::iosam_cmd_t          cmd,
  output      iosam_pkg::iosam_func_t         func
);
  import iosam_pkg::*;

  // Assignment registers, one code per terminal or bit
  logic [CODE_W-1:0]     map_cfg [N_MAP];
  logic [N_PROG-1:0]     prog_direct_out;
  logic [N_PROG-1:0]     prog_remote_out;
  logic [N_DOUT-1:0]     next_direct_out;
  logic [N_ROUT-1:0]     next_remote_out;
  logic [DATA_W-1:0]     next_rdata;

  // Bus decode
  wire                   in_map   = addr < (OFS_MAP + ADDR_W'(4 * N_MAP));
  wire [5:0]             slot     = addr[7:2];
  wire                   wr_map   = wr_stb & in_map & (addr[1:0] == 2'h0);

  // Per-slot register with its reset assignment
  for (genvar k = 0; k < N_MAP; k++) begin : g_map
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        map_cfg[k] <= iosam_default(k);
      end else if (wr_map && slot == 6'(k)) begin
        map_cfg[k] <= wdata[CODE_W-1:0];
      end
    end
  end

  // Packed views of the map groups for the resolvers
  logic [N_DIN-1:0][CODE_W-1:0]  din_codes;
  logic [N_RIN-1:0][CODE_W-1:0]  rin_codes;
  for (genvar t = 0; t < N_DIN; t++) begin : g_dinc
    assign din_codes[t] = map_cfg[SLOT_DIN + t];
  end
  for (genvar t = 0; t < N_RIN; t++) begin : g_rinc
    assign rin_codes[t] = map_cfg[SLOT_RIN + t];
  end

  // Which codes each side may carry; program groups are side-exclusive
  logic [NCODE-1:0] allow_direct;
  logic [NCODE-1:0] allow_remote;
  for (genvar f = 0; f < NCODE; f++) begin : g_allow
    localparam logic [CODE_W-1:0] C = CODE_W'(f);
    wire general = (C >= IN_STOP) && (C <= IN_TOOL_UNLOCK);
    assign allow_direct[f] = general | ((C & GROUP_MASK) == IN_PROG_DIRECT);
    assign allow_remote[f] = general | ((C & GROUP_MASK) == IN_PROG_REMOTE);
  end

  logic [NCODE-1:0] d_hit;
  logic [NCODE-1:0] d_asg;
  logic [NCODE-1:0] r_hit;
  logic [NCODE-1:0] r_asg;

  // OR of all terminals that share a function
  iosam_resolve #(.N(N_DIN)) u_direct (
    .lvl      (direct_in),
    .codes    (din_codes),
    .allow    (allow_direct),
    .hit      (d_hit),
    .assigned (d_asg)
  );

  iosam_resolve #(.N(N_RIN)) u_remote (
    .lvl      (remote_in),
    .codes    (rin_codes),
    .allow    (allow_remote),
    .hit      (r_hit),
    .assigned (r_asg)
  );

  // General functions: either side may activate
  wire [NCODE-1:0] any_hit = d_hit | r_hit;

  // Safety-type functions: default ON; when both sides are assigned, both must agree
  function automatic logic safe_level(input logic dh, input logic da,
                                      input logic rh, input logic ra);
    logic v;
    v = 1'b1;                 // Not assigned anywhere
    if (da && ra) begin
      v = dh & rh;
    end else if (da) begin
      v = dh;
    end else if (ra) begin
      v = rh;
    end
    return v;
  endfunction

  wire halt_on   = safe_level(d_hit[IN_EMERGENCY_HALT], d_asg[IN_EMERGENCY_HALT],
                              r_hit[IN_EMERGENCY_HALT], r_asg[IN_EMERGENCY_HALT]);
  wire unlock_on = safe_level(d_hit[IN_TOOL_UNLOCK], d_asg[IN_TOOL_UNLOCK],
                              r_hit[IN_TOOL_UNLOCK], r_asg[IN_TOOL_UNLOCK]);

  // Function outputs toward the core
  assign func.stop                    = any_hit[IN_STOP];
  assign func.robot_axes_unpower      = any_hit[IN_AXES_UNPOWER];
  assign func.driver_overtravel_clear = any_hit[IN_OVERTRAVEL_CLR];
  assign func.alarm_clear             = any_hit[IN_ALARM_CLEAR];
  assign func.pause                   = any_hit[IN_PAUSE];
  assign func.halt_request            = ~halt_on; // Normally closed
  assign func.operator_tool_unlock    = unlock_on;
  assign func.program_direct_input    = d_hit[IN_PROG_DIRECT +: N_PROG];
  assign func.program_remote_input    = r_hit[IN_PROG_REMOTE +: N_PROG];

  // Program outputs change only on the program signal-output command
  wire cmd_dir = cmd.valid & ~cmd.to_remote;
  wire cmd_rem = cmd.valid & cmd.to_remote;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_direct_out <= '0;
      prog_remote_out <= '0;
    end else begin
      // A set in the same cycle as a clear wins
      for (int i = 0; i < N_PROG; i++) begin
        if (cmd_dir && cmd.index == 4'(i)) begin
          prog_direct_out[i] <= cmd.value;
        end else if (cmd.clear_direct) begin
          prog_direct_out[i] <= 1'b0;
        end
        if (cmd_rem && cmd.index == 4'(i)) begin
          prog_remote_out[i] <= cmd.value;
        end else if (cmd.clear_remote) begin
          prog_remote_out[i] <= 1'b0;
        end
      end
    end
  end

  // Output source vector; index 0 stays low so unused outputs are inactive
  logic [NCODE-1:0] src_common;
  assign src_common = {
    {(NCODE - 2 * N_PROG){1'b0}},
    prog_direct_out,
    9'h000,
    status.program_running,
    status.pause_busy,
    ~status.alarm,
    status.driver_overtravel_monitor,
    status.motion_active,
    status.ready,
    1'b0
  };

  // Direct side cannot see program remote outputs
  wire [NCODE-1:0] src_direct = src_common;
  wire [NCODE-1:0] src_remote = {{(NCODE - 3 * N_PROG){1'b0}}, prog_remote_out,
                                 src_common[2*N_PROG-1:0]};

  for (genvar i = 0; i < N_DOUT; i++) begin : g_dout
    assign next_direct_out[i] = src_direct[map_cfg[SLOT_DOUT + i]];
  end
  for (genvar i = 0; i < N_ROUT; i++) begin : g_rout
    assign next_remote_out[i] = src_remote[map_cfg[SLOT_ROUT + i]];
  end

  // Registered terminal drive keeps pins free of decode glitches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      direct_out <= '0;
      remote_out <= '0;
    end else begin
      direct_out <= next_direct_out;
      remote_out <= next_remote_out;
    end
  end

  // Read mux; anything unmapped answers zero
  wire [DATA_W-1:0] func_bits = {func.program_remote_input, func.program_direct_input};
  assign next_rdata =
    in_map                  ? {{(DATA_W - CODE_W){1'b0}}, map_cfg[slot]} :
    (addr == OFS_FUNC_LO)   ? func_bits :
    (addr == OFS_FUNC_HI)   ? {25'h0000000, func.stop, func.robot_axes_unpower,
                               func.driver_overtravel_clear, func.alarm_clear,
                               func.pause, func.halt_request,
                               func.operator_tool_unlock} :
    (addr == OFS_DIRECT)    ? {16'h0000, direct_out, direct_in} :
    (addr == OFS_REMOTE)    ? {remote_out, remote_in} :
    (addr == OFS_PROG_OUT)  ? {prog_remote_out, prog_direct_out} :
                              32'h00000000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= rd_stb ? next_rdata : 32'h00000000;
    end
  end

endmodule

/* iosam_props.sv */
// Purpose: Port checks for the signal assignment map.
// Assumes: Default-map checks hold only while no map slot was written.
// Notes:   Any map write disarms them until the next reset.
`timescale 1ns/1ps
module iosam_props (
  input wire logic                         sys_clk,
  input wire logic                         rst,
  input wire logic [iosam_pkg::ADDR_W-1:0] addr,
  input wire logic                         wr_stb,
  input wire logic                         rd_stb,
  input wire logic [iosam_pkg::DATA_W-1:0] rdata,
  input wire logic [iosam_pkg::N_DIN-1:0]  direct_in,
  input wire logic [iosam_pkg::N_DOUT-1:0] direct_out,
  input wire logic [iosam_pkg::N_RIN-1:0]  remote_in,
  input wire logic [iosam_pkg::N_ROUT-1:0] remote_out,
  input wire iosam_pkg::iosam_status_t     status,
  input wire iosam_pkg::iosam_cmd_t        cmd,
  input wire iosam_pkg::iosam_func_t       func
);
  import iosam_pkg::*;
  logic dflt_q;
  // Map write in this cycle already spoils next-cycle checks
  wire  map_wr = wr_stb && (addr < OFS_FUNC_LO);
  // Off on the edge that leaves reset, while outputs still hold reset values
  wire  dflt   = dflt_q && !map_wr && !rst;

  // Armed at reset, cleared by the first map write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dflt_q <= 1'b1;
    end else if (map_wr) begin
      dflt_q <= 1'b0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  rdata_idle_a: assert property (!rd_stb |=> rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  dout_ready_a: assert property (dflt |=> direct_out[0] == $past(status.ready))
    else $error("output 0 does not follow ready");
  dout_alarm_a: assert property (dflt |=> direct_out[3] == !$past(status.alarm))
    else $error("output 3 not inverted alarm");
  din_funcs_a: assert property (dflt |-> {func.stop, func.robot_axes_unpower,
    func.driver_overtravel_clear, func.alarm_clear, func.pause} == {direct_in[0],
    direct_in[1], direct_in[2], direct_in[3], direct_in[4]})
    else $error("default input functions wrong");
  prog_din_a: assert property (dflt |-> func.program_direct_input == {14'h0, direct_in[7:6]})
    else $error("program direct inputs wrong");
  rin_dflt_a: assert property (dflt |-> func.program_remote_input == remote_in)
    else $error("remote inputs not mapped by default");
  unassigned_on_a: assert property (dflt |-> !func.halt_request && func.operator_tool_unlock)
    else $error("unassigned halt or unlock not on");
  rout_set_a: assert property (dflt && cmd.valid && cmd.to_remote && cmd.value
    |-> ##2 remote_out[$past(cmd.index, 2)])
    else $error("program remote output not set");
  rout_clear_a: assert property (dflt && cmd.clear_remote && !cmd.valid ##1 !cmd.valid
    |-> ##1 remote_out == 16'h0)
    else $error("remote outputs not cleared");
endmodule

bind iosam_top iosam_props i_iosam_props (.sys_clk(sys_clk), .rst(rst), .addr(addr),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .direct_in(direct_in),
  .direct_out(direct_out), .remote_in(remote_in), .remote_out(remote_out),
  .status(status), .cmd(cmd), .func(func));

/* iosam_far_model.sv */
// Purpose: Host controller and wiring on the far side of the map.
// Assumes: Host frames and equipment levels change once per clock.
// Notes:   Levels are registered, so they land one cycle after a request.
`timescale 1ns/1ps
module iosam_far_model (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic [iosam_pkg::N_RIN-1:0]  host_bits,
  input  wire logic [iosam_pkg::N_DIN-1:0]  equip_bits,
  output      logic [iosam_pkg::N_RIN-1:0]  remote_in,
  output      logic [iosam_pkg::N_DIN-1:0]  direct_in
);
  import iosam_pkg::*;
  // Host writes all sixteen remote bits each frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      remote_in <= 16'h0;
      direct_in <= 8'h00;
    end else begin
      remote_in <= host_bits;
      direct_in <= equip_bits;
    end
  end
endmodule

/* iosam_top_tb.sv */
// Purpose: Self-checking bench for the signal assignment map.
// Assumes: Far-side model drives the terminals and the remote bits.
// Notes:   Map-changing tests start from a fresh reset.
`timescale 1ns/1ps
module iosam_top_tb;
  import iosam_pkg::*;
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic [7:0]    addr = 8'h00;
  logic [31:0]   wdata = 32'h0;
  logic          wr_stb = 1'b0;
  logic          rd_stb = 1'b0;
  logic [31:0]   rdata;
  logic [7:0]    direct_in, direct_out, equip = 8'h00;
  logic [15:0]   remote_in, remote_out, host = 16'h0;
  iosam_status_t status = '0;
  iosam_cmd_t    cmd = '0;
  iosam_func_t   func;
  int            num_errors = 0;
  int            tests_run = 0;
  int            cyc = 0;
  logic [5:0]    tbl [16] = '{IN_STOP, IN_AXES_UNPOWER, IN_OVERTRAVEL_CLR, IN_ALARM_CLEAR,
    IN_PAUSE, IN_UNUSED, 6'h10, 6'h11, OUT_READY, OUT_MOTION, OUT_OVERTRAVEL_MON,
    OUT_ALARM_LOW, OUT_PAUSE_BUSY, OUT_PROG_RUNNING, 6'h10, 6'h11};
  wire [4:0]     core5 = {func.stop, func.robot_axes_unpower, func.driver_overtravel_clear,
    func.alarm_clear, func.pause};

  iosam_top i_iosam_top (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .direct_in(direct_in),
    .direct_out(direct_out), .remote_in(remote_in), .remote_out(remote_out),
    .status(status), .cmd(cmd), .func(func));
  iosam_far_model i_iosam_far_model (.sys_clk(sys_clk), .rst(rst), .host_bits(host),
    .equip_bits(equip), .remote_in(remote_in), .direct_in(direct_in));

  // 50 ns period
  always #25 sys_clk = ~sys_clk;

  task automatic give_verdict();
    $display("%0d comparisons, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Tests need well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t port %h expected %h", $time, got, exp);
    end
  endtask

  // Look at settled values mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic fresh();
    @(posedge sys_clk);
    rst <= 1'b1;
    status <= '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    chk_rd(rdata, e);
  endtask

  // Far side registers the levels, so allow one edge
  task automatic drive(input logic [7:0] d, input logic [15:0] r);
    @(posedge sys_clk);
    equip <= d;
    host <= r;
    settle(1);
  endtask

  // Program output command, then wait for the registered outputs
  task automatic go(input iosam_cmd_t c);
    @(posedge sys_clk);
    cmd <= c;
    @(posedge sys_clk);
    cmd <= '0;
    settle(1);
  endtask

  initial begin
    logic [5:0] e;
    logic [1:0] hu;
    fresh();
    for (int k = 0; k < 48; k++) begin
      e = (k < 16) ? tbl[k] : (6'h20 | 6'(k % 16));
      rd(8'(4 * k), {26'h0, e});
    end
    for (int i = 0; i < 8; i++) begin
      drive(8'h01 << i, 16'h0);
      chk_port(16'(core5), (i < 5) ? 16'(5'h10 >> i) : 16'h0);
      chk_port(func.program_direct_input, (i > 5) ? 16'(1 << (i - 6)) : 16'h0);
    end
    drive(8'h00, 16'ha5c3);
    chk_port(func.program_remote_input, 16'ha5c3);
    chk_port({func.halt_request, func.operator_tool_unlock}, 16'h1);
    // Status views: alarm low shows on output 3 while alarm is off
    rd(OFS_FUNC_LO, 32'ha5c3_0000);
    rd(OFS_FUNC_HI, 32'h0000_0001);
    rd(OFS_DIRECT, 32'h0000_0800);
    rd(OFS_REMOTE, 32'h0000_a5c3);
    for (int j = 0; j < 6; j++) begin
      @(posedge sys_clk);
      status <= 6'h20 >> j;
      settle(1);
      chk_port({remote_out[7:0], direct_out}, (8'h01 << j) ^ 8'h08);
    end
    @(posedge sys_clk);
    status <= '0;
    go('{1'b1, 1'b1, 4'h3, 1'b1, 1'b0, 1'b0});
    chk_port(remote_out, 16'h0008);
    go('{1'b1, 1'b0, 4'h1, 1'b1, 1'b0, 1'b0});
    chk_port({remote_out[7:0], direct_out}, 16'h0888);
    rd(OFS_PROG_OUT, 32'h0008_0002);
    go('{1'b1, 1'b1, 4'h5, 1'b1, 1'b0, 1'b1});
    chk_port(remote_out, 16'h0020);
    go('{1'b0, 1'b0, 4'h0, 1'b0, 1'b1, 1'b1});
    chk_port({remote_out[7:0], direct_out}, 16'h0008);
    $display("test defaults done");
    // Halt, then unlock, on both the direct and the remote side
    fresh();
    wr(8'h14, {26'h0, IN_EMERGENCY_HALT});
    wr(8'h40, {26'h0, IN_EMERGENCY_HALT});
    for (int c = 0; c < 8; c++) begin
      if (c == 4) begin
        wr(8'h14, {26'h0, IN_TOOL_UNLOCK});
        wr(8'h40, {26'h0, IN_TOOL_UNLOCK});
      end
      drive({2'b0, c[1], 5'h0}, {15'h0, c[0]});
      hu = (c < 4) ? {c[1:0] != 2'h3, 1'b1} : {1'b0, c[1:0] == 2'h3};
      chk_port({func.halt_request, func.operator_tool_unlock}, 16'(hu));
    end
    $display("test halt and unlock done");
    // Several terminals on one function, unused and remapped outputs
    fresh();
    wr(8'h14, {26'h0, IN_STOP});
    wr(8'h1c, {26'h0, IN_STOP});
    wr(8'h20, {26'h0, OUT_UNUSED});
    wr(8'h84, {26'h0, OUT_READY});
    wr(8'h01, 32'h3f);
    rd(8'h00, 32'h1);
    rd(8'hfc, 32'h0);
    for (int i = 0; i < 8; i++) begin
      drive(8'h01 << i, 16'h0);
      chk_port(16'(func.stop), 16'(i == 0 || i == 5 || i == 7));
    end
    @(posedge sys_clk);
    status <= 6'h20;
    settle(1);
    chk_port({remote_out[1], direct_out[0]}, 16'h2);
    $display("test remap done");
    give_verdict();
  end
endmodule
